// ---- design/jbs_pkg.sv ----
package jbs_pkg;

  // Test controller states
  typedef enum logic [3:0] {
    JBS_TLR, JBS_RTI, JBS_SEL_DR, JBS_CAP_DR, JBS_SHIFT_DR, JBS_EXIT1_DR,
    JBS_PAUSE_DR, JBS_EXIT2_DR, JBS_UPD_DR, JBS_SEL_IR, JBS_CAP_IR,
    JBS_SHIFT_IR, JBS_EXIT1_IR, JBS_PAUSE_IR, JBS_EXIT2_IR, JBS_UPD_IR
  } jbs_tap_type;

  // Selected test data register
  typedef enum logic [1:0] {JBS_SEL_BYPASS, JBS_SEL_CHAIN, JBS_SEL_ID} jbs_dr_type;

  // Instruction register defaults
  localparam int          IR_WIDTH_DEF  = 4;
  localparam logic [3:0]  OP_EXTEST     = 4'h0;
  localparam logic [3:0]  OP_SAMPLE     = 4'h1;
  localparam logic [3:0]  OP_IDCODE     = 4'h2;
  localparam logic [3:0]  OP_BYPASS     = 4'hF;
  localparam logic [1:0]  IR_CAPTURE    = 2'h1;
  // Arbitrary identification value
  localparam logic [31:0] ID_VALUE_DEF  = 32'h1234_5001;

  // Boundary cell chain
  localparam int CHAIN_LEN   = 26;
  localparam int NUM_OUT     = 10;
  localparam int NUM_IN      = 13;
  localparam int CELL_RX3_OUTPUT_DISABLE_CELL   = 2;
  localparam int CELL_RX2_OUTPUT_DISABLE_CELL   = 10;
  localparam int CELL_ACKENB = 19;
  // Output pins: loss_of_signal_ch3 rx_negative_data_ch3 rx_positive_data_ch3 rx_recovered_clock_ch3 loss_of_signal_ch2 rx_negative_data_ch2 rx_positive_data_ch2 rx_recovered_clock_ch2 int ack
  localparam int CELL_OUT [NUM_OUT] = '{0, 1, 3, 4, 8, 9, 11, 12, 18, 20};
  // Input pins: tx_negative_data_ch3 tx_positive_data_ch3 tx_clock_ch3 tneg2 tpos2 tclk2 mclk mode ale oe clock_edge_select_input a0 a1
  localparam int CELL_IN  [NUM_IN]  = '{5, 6, 7, 13, 14, 15, 16, 17, 21, 22, 23, 24, 25};
  localparam int OUT_ACK   = 9;

  // Register map, byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ID     = 4'h8;
  localparam int         CTRL_ENABLE_BIT = 0;
  localparam logic       CTRL_RESET      = 1'b1;
  localparam int         STAT_IR_LSB     = 8;

endpackage

// ---- design/jbs_sync.sv ----
`timescale 1ns/1ps

module jbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ---- design/jbs_tap.sv ----
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps

// Summary of operation
// - Test controller is a sixteen state synchronous machine.
// - Mode-select steers transitions on test clock rising edges; clearing the enable bit forces reset.
// - Reset state loads identification instruction, pins run normally.
// - Idle state holds while mode-select is sampled low.
// - Capture data state loads the chain from the pins.
// - Shift data state moves the selected register toward serial output.
// - Update data state latches the chain into the pin latches.
// - Capture instruction state preloads a fixed pattern.
// - Shift instruction state moves the instruction stage one bit.
// - Update instruction state makes the shifted instruction active.
// - Pause states hold the shift paths unchanged.
// - Exit states are transient and can end a scan.
// - Chain data enters least significant bit first.
// - Chain reaches every digital input and output pin.
// - Chain order starts at loss_of_signal_ch3, then ch3 rx, tx, then ch2.
// - Tristatable pins get a separate output control cell.
// - Rx disable cell 0 drives, 1 tristates pos, neg and clock.
// - Ack disable cell 0 drives, 1 tristates the ack pin.
module jbs_tap
  import jbs_pkg::*;
#(
  parameter int                   IR_WIDTH   = IR_WIDTH_DEF,
  parameter logic [IR_WIDTH-1:0]  OPC_EXTEST = IR_WIDTH'(OP_EXTEST),
  parameter logic [IR_WIDTH-1:0]  OPC_SAMPLE = IR_WIDTH'(OP_SAMPLE),
  parameter logic [IR_WIDTH-1:0]  OPC_IDCODE = IR_WIDTH'(OP_IDCODE),
  parameter logic [IR_WIDTH-1:0]  OPC_BYPASS = IR_WIDTH'(OP_BYPASS),
  parameter logic [31:0]          ID_VALUE   = ID_VALUE_DEF
) (
  input  wire logic               clk,
  input  wire logic               srst,
  // Test port pins
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe_n,
  // Device pins and the core behind them
  input  wire logic [NUM_IN-1:0]  pin_in,
  input  wire logic [NUM_OUT-1:0] core_out,
  input  wire logic               core_rx3_oe_n,
  input  wire logic               core_rx2_oe_n,
  input  wire logic               core_ack_oe_n,
  output logic      [NUM_OUT-1:0] pin_out,
  output logic                    rx3_oe_n,
  output logic                    rx2_oe_n,
  output logic                    ack_oe_n,
  output logic                    test_active,
  // Avalon-MM slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest
);

  initial begin
    if (IR_WIDTH < 2 || IR_WIDTH > 16) begin
      $error("IR_WIDTH must lie between 2 and 16");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    jbs_tap_type             state;
    logic                    tck_prev;
    logic [IR_WIDTH-1:0]     ir_shift;
    logic [IR_WIDTH-1:0]     ir_active;
    logic [CHAIN_LEN-1:0]    chain;
    logic [CHAIN_LEN-1:0]    latch;
    logic [31:0]             id_shift;
    logic                    bypass;
    logic                    tdo;
    logic                    tdo_oe_n;
    logic [NUM_OUT-1:0]      pin_out;
    logic                    rx3_oe_n;
    logic                    rx2_oe_n;
    logic                    ack_oe_n;
    logic                    test_active;
    logic                    enable;
    logic [31:0]             readdata;
    logic                    waitrequest;
  } jbs_regs_type;

  jbs_regs_type      r;
  jbs_regs_type      next_r;
  logic [NUM_IN+2:0] synced;
  logic              tck_s;
  logic              tms_s;
  logic              tdi_s;
  logic [NUM_IN-1:0] pin_s;

  // Pins come from outside the clock domain
  jbs_sync #(
    .WIDTH    (NUM_IN + 3)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({pin_in, tdi, tms, tck}),
    .sync_out (synced)
  );

  assign tck_s = synced[0];
  assign tms_s = synced[1];
  assign tdi_s = synced[2];
  assign pin_s = synced[NUM_IN+2:3];

  ////////////////////////////////////////////////////////////////////////////////

  // Standard transition graph
  function automatic jbs_tap_type tap_next(input jbs_tap_type s, input logic m);
    jbs_tap_type n;
    n = s;
    case (s)
      JBS_TLR:      n = m ? JBS_TLR : JBS_RTI;
      JBS_RTI:      n = m ? JBS_SEL_DR : JBS_RTI;
      JBS_SEL_DR:   n = m ? JBS_SEL_IR : JBS_CAP_DR;
      JBS_CAP_DR:   n = m ? JBS_EXIT1_DR : JBS_SHIFT_DR;
      JBS_SHIFT_DR: n = m ? JBS_EXIT1_DR : JBS_SHIFT_DR;
      JBS_EXIT1_DR: n = m ? JBS_UPD_DR : JBS_PAUSE_DR;
      JBS_PAUSE_DR: n = m ? JBS_EXIT2_DR : JBS_PAUSE_DR;
      JBS_EXIT2_DR: n = m ? JBS_UPD_DR : JBS_SHIFT_DR;
      JBS_UPD_DR:   n = m ? JBS_SEL_DR : JBS_RTI;
      JBS_SEL_IR:   n = m ? JBS_TLR : JBS_CAP_IR;
      JBS_CAP_IR:   n = m ? JBS_EXIT1_IR : JBS_SHIFT_IR;
      JBS_SHIFT_IR: n = m ? JBS_EXIT1_IR : JBS_SHIFT_IR;
      JBS_EXIT1_IR: n = m ? JBS_UPD_IR : JBS_PAUSE_IR;
      JBS_PAUSE_IR: n = m ? JBS_EXIT2_IR : JBS_PAUSE_IR;
      JBS_EXIT2_IR: n = m ? JBS_UPD_IR : JBS_SHIFT_IR;
      JBS_UPD_IR:   n = m ? JBS_SEL_DR : JBS_RTI;
      default:      n = JBS_TLR;
    endcase
    return n;
  endfunction

  // Instruction decode, unknown codes fall back to bypass
  function automatic jbs_dr_type dr_select(input logic [IR_WIDTH-1:0] ir);
    jbs_dr_type d;
    d = JBS_SEL_BYPASS;
    if (ir == OPC_EXTEST || ir == OPC_SAMPLE) begin
      d = JBS_SEL_CHAIN;
    end else if (ir == OPC_IDCODE) begin
      d = JBS_SEL_ID;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic       tck_rise;
  logic       tck_fall;
  logic       extest;
  jbs_dr_type sel;

  always_comb begin
    next_r   = r;
    tck_rise = tck_s & ~r.tck_prev;
    tck_fall = ~tck_s & r.tck_prev;
    sel      = dr_select(r.ir_active);
    extest   = (r.ir_active == OPC_EXTEST);
    next_r.tck_prev = tck_s;

    // Rising test clock: capture, shift and state step
    if (tck_rise) begin
      case (r.state)
        JBS_CAP_DR: begin
          case (sel)
            JBS_SEL_CHAIN: begin
              for (int i = 0; i < NUM_OUT; i++) begin
                next_r.chain[CELL_OUT[i]] = r.pin_out[i];
              end
              for (int i = 0; i < NUM_IN; i++) begin
                next_r.chain[CELL_IN[i]] = pin_s[i];
              end
              // Control cells have no pin, read back the latch
              next_r.chain[CELL_RX3_OUTPUT_DISABLE_CELL]   = r.latch[CELL_RX3_OUTPUT_DISABLE_CELL];
              next_r.chain[CELL_RX2_OUTPUT_DISABLE_CELL]   = r.latch[CELL_RX2_OUTPUT_DISABLE_CELL];
              next_r.chain[CELL_ACKENB] = r.latch[CELL_ACKENB];
            end
            JBS_SEL_ID: next_r.id_shift = ID_VALUE;
            default:    next_r.bypass   = 1'b0;
          endcase
        end
        JBS_SHIFT_DR: begin
          case (sel)
            JBS_SEL_CHAIN: next_r.chain = {tdi_s, r.chain[CHAIN_LEN-1:1]};
            JBS_SEL_ID:    next_r.id_shift = {tdi_s, r.id_shift[31:1]};
            default:       next_r.bypass = tdi_s;
          endcase
        end
        JBS_CAP_IR: begin
          next_r.ir_shift = IR_WIDTH'(IR_CAPTURE);
        end
        JBS_SHIFT_IR: begin
          next_r.ir_shift = {tdi_s, r.ir_shift[IR_WIDTH-1:1]};
        end
        default: begin
          // Pause, exit and the rest leave both paths alone
          next_r.chain = r.chain;
        end
      endcase
      next_r.state = tap_next(r.state, tms_s);
    end

    // Falling test clock: updates and serial output
    if (tck_fall) begin
      if (r.state == JBS_UPD_DR && sel == JBS_SEL_CHAIN) begin
        next_r.latch = r.chain;
      end
      if (r.state == JBS_UPD_IR) begin
        next_r.ir_active = r.ir_shift;
      end
      if (r.state == JBS_SHIFT_DR) begin
        case (sel)
          JBS_SEL_CHAIN: next_r.tdo = r.chain[0];
          JBS_SEL_ID:    next_r.tdo = r.id_shift[0];
          default:       next_r.tdo = r.bypass;
        endcase
        next_r.tdo_oe_n = 1'b0;
      end else if (r.state == JBS_SHIFT_IR) begin
        next_r.tdo      = r.ir_shift[0];
        next_r.tdo_oe_n = 1'b0;
      end else begin
        next_r.tdo_oe_n = 1'b1;
      end
    end

    // Reset state forces the identification instruction
    if (r.state == JBS_TLR) begin
      next_r.ir_active = OPC_IDCODE;
    end

    // Disabled port parks the controller in reset
    if (!r.enable) begin
      next_r.state    = JBS_TLR;
      next_r.tdo_oe_n = 1'b1;
    end

    // Pin drive: core in normal operation, latches under external test
    for (int i = 0; i < NUM_OUT; i++) begin
      next_r.pin_out[i] = extest ? r.latch[CELL_OUT[i]] : core_out[i];
    end
    next_r.rx3_oe_n    = extest ? r.latch[CELL_RX3_OUTPUT_DISABLE_CELL] : core_rx3_oe_n;
    next_r.rx2_oe_n    = extest ? r.latch[CELL_RX2_OUTPUT_DISABLE_CELL] : core_rx2_oe_n;
    next_r.ack_oe_n    = extest ? r.latch[CELL_ACKENB] : core_ack_oe_n;
    next_r.test_active = extest;

    // Avalon slave: one wait cycle, then a single-cycle answer
    next_r.waitrequest = 1'b1;
    if ((avs_read || avs_write) && r.waitrequest) begin
      next_r.waitrequest = 1'b0;
      next_r.readdata    = '0;
      if (avs_address == REG_CTRL) begin
        next_r.readdata[CTRL_ENABLE_BIT] = r.enable;
        if (avs_write) begin
          next_r.enable = avs_writedata[CTRL_ENABLE_BIT];
        end
      end else if (avs_address == REG_STATUS) begin
        next_r.readdata[3:0] = r.state;
        next_r.readdata[STAT_IR_LSB +: IR_WIDTH] = r.ir_active;
      end else if (avs_address == REG_ID) begin
        next_r.readdata = ID_VALUE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (srst) begin
      r             <= '0;
      r.state       <= JBS_TLR;
      r.ir_active   <= OPC_IDCODE;
      // Tristate all controlled pins in reset; control latches keep them so under external test until an update
      r.latch[CELL_RX3_OUTPUT_DISABLE_CELL]   <= 1'b1;
      r.latch[CELL_RX2_OUTPUT_DISABLE_CELL]   <= 1'b1;
      r.latch[CELL_ACKENB] <= 1'b1;
      r.tdo_oe_n    <= 1'b1;
      r.rx3_oe_n    <= 1'b1;
      r.rx2_oe_n    <= 1'b1;
      r.ack_oe_n    <= 1'b1;
      r.enable      <= CTRL_RESET;
      r.waitrequest <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign tdo             = r.tdo;
  assign tdo_oe_n        = r.tdo_oe_n;
  assign pin_out         = r.pin_out;
  assign rx3_oe_n        = r.rx3_oe_n;
  assign rx2_oe_n        = r.rx2_oe_n;
  assign ack_oe_n        = r.ack_oe_n;
  assign test_active     = r.test_active;
  assign avs_readdata    = r.readdata;
  assign avs_waitrequest = r.waitrequest;

endmodule

// ---- sim/jbs_tap_checker.sv ----
`timescale 1ns/1ps
module jbs_tap_checker
  import jbs_pkg::*;
(
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdo,
  input wire logic               tdo_oe_n,
  input wire logic [NUM_OUT-1:0] core_out,
  input wire logic               core_rx3_oe_n,
  input wire logic               core_rx2_oe_n,
  input wire logic               core_ack_oe_n,
  input wire logic [NUM_OUT-1:0] pin_out,
  input wire logic               rx3_oe_n,
  input wire logic               rx2_oe_n,
  input wire logic               ack_oe_n,
  input wire logic               test_active,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest
);
  logic       tck_q;
  logic [2:0] hi_cnt;
  // Raw pin edges; tms is stable around a rising test clock
  always_ff @(posedge clk) begin
    tck_q <= tck;
    if (srst) hi_cnt <= 3'h0;
    else if (tck && !tck_q) hi_cnt <= !tms ? 3'h0 : (hi_cnt == 3'h5 ? 3'h5 : hi_cnt + 3'h1);
  end
  //////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_quiet;
    !test_active && $past(!test_active) && !$past(srst, 2);
  endsequence
  chk_reset_vals: assert property (disable iff (1'b0) srst |=>
    tdo_oe_n && rx3_oe_n && rx2_oe_n && ack_oe_n && !test_active && pin_out == 10'h000)
    else $error("reset values wrong");
  chk_wait_answer: assert property (s_req |=> !avs_waitrequest) else $error("no answer");
  chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  chk_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("ack without request");
  chk_read_hold: assert property (avs_waitrequest && !$past(srst) |-> $stable(avs_readdata))
    else $error("readdata moved");
  chk_tdo_low: assert property (!$stable(tdo) && !$past(srst) |-> !tck)
    else $error("tdo moved on high clock");
  chk_oe_fall: assert property ($fell(tdo_oe_n) |-> !tck) else $error("tdo enabled late");
  chk_normal_pins: assert property (s_quiet |-> pin_out == $past(core_out))
    else $error("pins not from core");
  chk_normal_enable: assert property (s_quiet |-> rx3_oe_n == $past(core_rx3_oe_n)
    && rx2_oe_n == $past(core_rx2_oe_n) && ack_oe_n == $past(core_ack_oe_n))
    else $error("enables not from core");
  chk_tms_reset: assert property (hi_cnt == 3'h5 |-> ##[0:8] !test_active)
    else $error("no reset after five");
endmodule

// ---- sim/jbs_tester.sv ----
`timescale 1ns/1ps
module jbs_tester (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // 8 clk per half gives 160 ns; clock stands low between calls
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    tck <= 1'b1;
    q = tdo;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask
  // Idle data toggles so a stale level is never mistaken for data
  task automatic move(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask
  task automatic scan(input logic ir, input int n, input int p, input logic [31:0] din,
                      output logic [31:0] dout);
    dout = 32'h0;
    move(1'b1);
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p - 1, din[i], dout[i]);
      if (i == p - 1) begin
        repeat (3) move(1'b0);
        move(1'b1);
        move(1'b0);
      end
    end
    move(1'b1);
    move(1'b0);
  endtask
endmodule

// ---- sim/test_jbs_tap.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module test_jbs_tap
  import jbs_pkg::*;
();
  logic               clk, srst, tck, tms, tdi, tdo, tdo_oe_n, test_active;
  logic               rx3_oe_n, rx2_oe_n, ack_oe_n, core_rx3_oe_n, core_rx2_oe_n, core_ack_oe_n;
  logic               avs_read, avs_write, avs_waitrequest;
  logic [NUM_IN-1:0]  pin_in;
  logic [NUM_OUT-1:0] core_out, pin_out;
  logic [3:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata, rd, sh;
  int                 failures, total_checks;
  jbs_tap jbs_tap_i (.clk, .srst, .tck, .tms, .tdi, .tdo, .tdo_oe_n, .pin_in, .core_out,
    .core_rx3_oe_n, .core_rx2_oe_n, .core_ack_oe_n, .pin_out, .rx3_oe_n, .rx2_oe_n,
    .ack_oe_n, .test_active, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest);
  jbs_tester jbs_tester_i (.clk, .tck, .tms, .tdi, .tdo);
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic st(input logic [3:0] s, input logic [3:0] op);
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("status", {op, s}, {rd[11:8], rd[3:0]})
  endtask
  task automatic t_reset();
    `CHK("tdo_oe_n", 1'b1, tdo_oe_n)
    `CHK("pin_out", core_out, pin_out)
    st(4'h0, OP_IDCODE);
    bus(1'b1, REG_ID, 32'h0);
    bus(1'b0, REG_ID, 32'h0);
    `CHK("id", ID_VALUE_DEF, rd)
    bus(1'b0, 4'hC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask
  task automatic t_idcode();
    repeat (3) jbs_tester_i.move(1'b0);
    st(4'h1, OP_IDCODE);
    jbs_tester_i.scan(1'b0, 32, 16, 32'h0, sh);
    `CHK("idcode", ID_VALUE_DEF, sh)
  endtask
  task automatic t_ir();
    jbs_tester_i.scan(1'b1, 8, 0, {24'h0, OP_EXTEST, 4'h5}, sh);
    `CHK("ir capture", IR_CAPTURE, sh[1:0])
    `CHK("ir shift", 4'h5, sh[7:4])
    st(4'h1, OP_EXTEST);
  endtask
  task automatic t_extest();
    logic [31:0] pat;
    pat = 32'h02C6A3DD;
    jbs_tester_i.scan(1'b0, CHAIN_LEN, 0, pat, sh);
    for (int k = 0; k < NUM_IN; k++) `CHK("in cell", pin_in[k], sh[CELL_IN[k]])
    `CHK("ctl cells", 3'h7, {sh[CELL_RX3_OUTPUT_DISABLE_CELL], sh[CELL_RX2_OUTPUT_DISABLE_CELL], sh[CELL_ACKENB]})
    repeat (4) @(posedge clk);
    for (int k = 0; k < NUM_OUT; k++) `CHK("out pin", pat[CELL_OUT[k]], pin_out[k])
    `CHK("rx oe", 2'h2, {rx3_oe_n, rx2_oe_n})
    `CHK("ack oe", 1'b0, ack_oe_n)
    `CHK("test_active", 1'b1, test_active)
  endtask
  task automatic t_tms_reset();
    core_out <= 10'h149;
    {core_rx3_oe_n, core_rx2_oe_n, core_ack_oe_n} <= 3'h5;
    jbs_tester_i.move(1'b1);
    repeat (2) jbs_tester_i.move(1'b0);
    repeat (5) jbs_tester_i.move(1'b1);
    st(4'h0, OP_IDCODE);
    `CHK("pin_out", 10'h149, pin_out)
    `CHK("core oe", 3'h5, {rx3_oe_n, rx2_oe_n, ack_oe_n})
  endtask
  // Disabled port must ignore the test clock entirely
  task automatic t_disable();
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (2) jbs_tester_i.move(1'b0);
    st(4'h0, OP_IDCODE);
    bus(1'b1, REG_CTRL, 32'h1);
    jbs_tester_i.move(1'b0);
    st(4'h1, OP_IDCODE);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    #100us;
    failures++;
    report_and_stop();
  end
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    pin_in = 13'h1A5B;
    core_out = 10'h2B6;
    {core_rx3_oe_n, core_rx2_oe_n, core_ack_oe_n} = 3'h2;
    {avs_read, avs_write, avs_address, avs_writedata} = 38'h0;
    failures = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_idcode();
    t_ir();
    t_extest();
    t_tms_reset();
    t_disable();
    report_and_stop();
  end
endmodule
bind jbs_tap jbs_tap_checker jbs_tap_checker_i (.clk, .srst, .tck, .tms, .tdo, .tdo_oe_n,
  .core_out, .core_rx3_oe_n, .core_rx2_oe_n, .core_ack_oe_n, .pin_out, .rx3_oe_n,
  .rx2_oe_n, .ack_oe_n, .test_active, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest);
